// ===== verilog/tdpwm_pkg.sv
// Constants shared by the three-phase dead-time PWM generator and its dead-time unit.
// Assumes a classic Wishbone slave with 32-bit data and word-aligned registers.
//
// Notes on behaviour
// R1 - While stopped, software loads the up/down counter with twice the dead time.
// R2 - Running, counter rises to period compare, falls to twice dead time, repeats.
// R3 - Counter compared with mid always; up and period rising; down and 2Td falling.
// R4 - Even dead-time counters start on positive compare fall while falling; stop at value.
// R5 - Odd dead-time counters start on negative compare fall while rising; stop at value.
// R6 - Dead-time counters compare only while counting, never count at zero, read-only.
// R7 - Period buffer feeds period compare; each duty buffer feeds three compares.
// R8 - Buffers always accessible; buffered writes move on timing, free writes immediately.
// R9 - Transfer: mid = duty+Td, up = duty+2Td, down = duty, period = buffer+2Td.
// R10 - Software keeps duty and period buffers inside their allowed ranges.
// R11 - Software initialises period, dead time, period compare and free duties first.
// R12 - Separate active levels for the positive and the negative phase outputs.
// R13 - Software changes output levels only outside the operating mode.
// R14 - Software changes the dead time value only outside the operating mode.
// R15 - Period moved at crest acts next period; moved at trough acts same period.
// R16 - Each phase output is compare wave ANDed with dead-time wave, all phases alike.
// R17 - Compare wave A: rising uses up compare, falling uses mid compare.
// R18 - Compare wave B: rising uses mid compare, falling uses down compare.
// R19 - Six PWM pins, a toggle pin and an active-low counter clear input.
// R20 - Dead-time wave is 1 initially, 0 while its counter counts.
// R21 - Output A is compare A and dead-time B; output B is compare B and dead-time A.
// R22 - Toggle output is 1 while counting up, 0 while counting down.
// R23 - Falling edge on counter clear reloads twice the dead time and counts up; the code acts on the edge only in the operating mode.
// R24 - Transfer timing field selects crest, trough or both.
package tdpwm_pkg;
   localparam int DW = 16;
   // Word byte addresses of the register map.
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STAT = 8'h04;
   localparam logic [7:0] OFS_CNT = 8'h08;
   localparam logic [7:0] OFS_DTV = 8'h0C;
   localparam logic [7:0] OFS_PBUF = 8'h10;
   localparam logic [7:0] OFS_PCMP = 8'h14;
   localparam logic [7:0] OFS_DBUF = 8'h18;
   localparam logic [7:0] OFS_DFREE = 8'h24;
   localparam logic [7:0] OFS_MID = 8'h30;
   localparam logic [7:0] OFS_UP = 8'h3C;
   localparam logic [7:0] OFS_DOWN = 8'h48;
   localparam logic [7:0] OFS_DTC = 8'h54;
   // Control register fields.
   localparam int CTRL_RUN = 0;
   localparam int CTRL_MD_LO = 1;
   localparam int CTRL_PLS = 3;
   localparam int CTRL_NLS = 4;
   localparam logic [4:0] CTRL_RST = 5'h00;
   // Transfer timing codes; zero leaves the operating mode.
   localparam logic [1:0] MD_OFF = 2'h0;
   localparam logic [1:0] MD_CREST = 2'h1;
   localparam logic [1:0] MD_TROUGH = 2'h2;
   localparam logic [1:0] MD_BOTH = 2'h3;
   localparam logic [15:0] REG16_RST = 16'h0000;
   localparam logic [15:0] DT_ONE = 16'h0001;
endpackage

// ===== verilog/tdpwm_deadtime.sv
// Dead-time unit of one phase: two up-counters and their dead-time waves.
// Assumes the compare waves and direction come from registers in the same clock domain.
`timescale 1ns/1ps
module tdpwm_deadtime (
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic run,
   input wire logic dir_up,
   input wire logic cmp_a,
   input wire logic cmp_b,
   input wire logic [15:0] dead_time,
   output logic dtw_a,
   output logic dtw_b,
   output logic [15:0] cnt_even,
   output logic [15:0] cnt_odd
);
   logic cmp_a_reg;
   logic cmp_b_reg;
   logic busy_a_reg;
   logic busy_b_reg;
   wire start_a;
   wire start_b;
   wire done_a;
   wire done_b;

   // Starts qualify on direction; a zero dead time never starts a count.
   assign start_a = run && cmp_a_reg && !cmp_a && !dir_up && (dead_time != 16'h0000); // R4 R6
   assign start_b = run && cmp_b_reg && !cmp_b && dir_up && (dead_time != 16'h0000); // R5 R6
   assign done_a = busy_a_reg && (cnt_even == dead_time); // R6
   assign done_b = busy_b_reg && (cnt_odd == dead_time); // R6
   assign dtw_a = !busy_a_reg; // R20
   assign dtw_b = !busy_b_reg; // R20

   // Edge history and the two counters; reaching the value clears and halts.
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         cmp_a_reg <= 1'b0;
         cmp_b_reg <= 1'b0;
         busy_a_reg <= 1'b0;
         busy_b_reg <= 1'b0;
         cnt_even <= tdpwm_pkg::REG16_RST;
         cnt_odd <= tdpwm_pkg::REG16_RST;
      end else if (run) begin
         cmp_a_reg <= cmp_a;
         cmp_b_reg <= cmp_b;
         if (done_a) begin
            busy_a_reg <= 1'b0; // R4
            cnt_even <= tdpwm_pkg::REG16_RST;
         end else if (busy_a_reg || start_a) begin
            busy_a_reg <= 1'b1;
            cnt_even <= cnt_even + tdpwm_pkg::DT_ONE;
         end
         if (done_b) begin
            busy_b_reg <= 1'b0; // R5
            cnt_odd <= tdpwm_pkg::REG16_RST;
         end else if (busy_b_reg || start_b) begin
            busy_b_reg <= 1'b1;
            cnt_odd <= cnt_odd + tdpwm_pkg::DT_ONE;
         end
      end
   end

   a_even_stop: assert property (@(posedge mclk) disable iff (!arst_n) // R4
      run && done_a |=> !busy_a_reg && cnt_even == 16'h0000)
      else $error("even dead-time counter did not clear and halt");
   a_odd_start: assert property (@(posedge mclk) disable iff (!arst_n) // R5
      run && start_b && !busy_b_reg |=> busy_b_reg && cnt_odd == 16'h0001)
      else $error("odd dead-time counter did not start");
   a_zero_idle: assert property (@(posedge mclk) disable iff (!arst_n) // R6
      dead_time == 16'h0000 && !busy_a_reg |=> !busy_a_reg)
      else $error("dead-time counter ran with zero dead time");
endmodule

// ===== verilog/tdpwm_top.sv
// Three-phase complementary PWM generator with dead time and a Wishbone register file.
// Assumes a classic Wishbone master on mclk and a synchronous active-low clear input.
`timescale 1ns/1ps
module tdpwm_top (
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic counter_clear_n,
   output logic phase_u_out_a,
   output logic phase_u_out_b,
   output logic phase_v_out_a,
   output logic phase_v_out_b,
   output logic phase_w_out_a,
   output logic phase_w_out_b,
   output logic carrier_toggle_out
);
   // Sum cut to the register width; wrap is software's to avoid by range limits.
   function automatic logic [15:0] add16(input logic [15:0] a, input logic [15:0] b);
      add16 = a + b;
   endfunction

   // Phase index of a three-word block, or 3 when the address is outside it.
   function automatic logic [1:0] pidx(input logic [7:0] adr, input logic [7:0] base);
      logic [7:0] d;
      d = adr - base;
      pidx = (adr >= base && d < 8'h0C && d[1:0] == 2'h0) ? d[3:2] : 2'h3;
   endfunction

   logic [4:0] ctrl_reg;
   logic [15:0] cnt_reg;
   logic [15:0] cnt_next;
   logic dir_reg;
   logic dir_next;
   logic [15:0] dtv_reg;
   logic [15:0] pbuf_reg;
   logic [15:0] pcmp_reg;
   logic [15:0] dbuf_reg [3];
   logic [15:0] mid_reg [3];
   logic [15:0] up_reg [3];
   logic [15:0] down_reg [3];
   logic clr_n_reg;
   logic [2:0] out_a_reg;
   logic [2:0] out_b_reg;
   logic [2:0] cmp_a;
   logic [2:0] cmp_b;
   logic [2:0] dtw_a;
   logic [2:0] dtw_b;
   logic [15:0] dtc [6];
   logic [31:0] rdat;

   wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   wire wr = req && wb_we_i && (wb_sel_i[1:0] == 2'h3);
   wire [15:0] wdat = wb_dat_i[15:0];
   wire [1:0] md = ctrl_reg[tdpwm_pkg::CTRL_MD_LO +: 2];
   wire operating = (md != tdpwm_pkg::MD_OFF);
   wire run = operating && ctrl_reg[tdpwm_pkg::CTRL_RUN];
   wire pls = ctrl_reg[tdpwm_pkg::CTRL_PLS];
   wire nls = ctrl_reg[tdpwm_pkg::CTRL_NLS];
   wire [15:0] two_td = add16(dtv_reg, dtv_reg);
   wire [1:0] dbuf_sel = pidx(wb_adr_i, tdpwm_pkg::OFS_DBUF);
   wire [1:0] dfree_sel = pidx(wb_adr_i, tdpwm_pkg::OFS_DFREE);
   wire wr_ctrl = wr && wb_adr_i == tdpwm_pkg::OFS_CTRL;
   wire wr_cnt = wr && wb_adr_i == tdpwm_pkg::OFS_CNT && !ctrl_reg[tdpwm_pkg::CTRL_RUN];
   wire wr_dtv = wr && wb_adr_i == tdpwm_pkg::OFS_DTV;
   wire wr_pbuf = wr && wb_adr_i == tdpwm_pkg::OFS_PBUF;
   wire wr_pcmp = wr && wb_adr_i == tdpwm_pkg::OFS_PCMP;
   wire wr_dbuf = wr && dbuf_sel != 2'h3;
   wire wr_free = wr && dfree_sel != 2'h3;

   // Turning points of the triangle and the external clear edge.
   wire crest = run && dir_reg && cnt_reg == pcmp_reg; // R2 R3
   wire trough = run && !dir_reg && cnt_reg == two_td; // R2 R3
   wire clr_fall = operating && clr_n_reg && !counter_clear_n; // R23
   wire xfer = (crest && md[0]) || (trough && md[1]); // R24 R15

   // Next counter state: clear edge first, then software load, then counting.
   always_comb begin
      cnt_next = cnt_reg;
      dir_next = dir_reg;
      if (clr_fall) begin
         cnt_next = two_td; // R23
         dir_next = 1'b1;
      end else if (wr_cnt) begin
         cnt_next = wdat; // R1
      end else if (crest) begin
         cnt_next = cnt_reg - tdpwm_pkg::DT_ONE; // R2
         dir_next = 1'b0;
      end else if (trough) begin
         cnt_next = cnt_reg + tdpwm_pkg::DT_ONE; // R2
         dir_next = 1'b1;
      end else if (run) begin
         cnt_next = dir_reg ? cnt_reg + tdpwm_pkg::DT_ONE : cnt_reg - tdpwm_pkg::DT_ONE; // R2
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_reg <= tdpwm_pkg::REG16_RST;
         dir_reg <= 1'b1;
         clr_n_reg <= 1'b1;
      end else begin
         cnt_reg <= cnt_next;
         dir_reg <= dir_next;
         clr_n_reg <= counter_clear_n;
      end
   end

   // Control, dead time and period registers; a timed transfer beats a direct write.
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         ctrl_reg <= tdpwm_pkg::CTRL_RST;
         dtv_reg <= tdpwm_pkg::REG16_RST;
         pbuf_reg <= tdpwm_pkg::REG16_RST;
         pcmp_reg <= tdpwm_pkg::REG16_RST;
      end else begin
         if (wr_ctrl) ctrl_reg <= wdat[4:0];
         if (wr_dtv) dtv_reg <= wdat;
         if (wr_pbuf) pbuf_reg <= wdat;
         if (xfer) pcmp_reg <= add16(pbuf_reg, two_td); // R7 R9 R8
         else if (wr_pcmp) pcmp_reg <= wdat;
      end
   end

   // Per-phase duty buffer and its three compares.
   for (genvar p = 0; p < 3; p++) begin : g_phase
      always_ff @(posedge mclk or negedge arst_n) begin
         if (!arst_n) begin
            dbuf_reg[p] <= tdpwm_pkg::REG16_RST;
            mid_reg[p] <= tdpwm_pkg::REG16_RST;
            up_reg[p] <= tdpwm_pkg::REG16_RST;
            down_reg[p] <= tdpwm_pkg::REG16_RST;
         end else if (wr_free && dfree_sel == 2'(p)) begin
            dbuf_reg[p] <= wdat; // R8
            mid_reg[p] <= add16(wdat, dtv_reg); // R9
            up_reg[p] <= add16(wdat, two_td);
            down_reg[p] <= wdat;
         end else begin
            if (wr_dbuf && dbuf_sel == 2'(p)) dbuf_reg[p] <= wdat;
            if (xfer) begin
               mid_reg[p] <= add16(dbuf_reg[p], dtv_reg); // R7 R9
               up_reg[p] <= add16(dbuf_reg[p], two_td);
               down_reg[p] <= dbuf_reg[p];
            end
         end
      end

      // Compare waves follow the direction of the count.
      assign cmp_a[p] = dir_reg ? !(up_reg[p] > cnt_reg) : !(mid_reg[p] > cnt_reg); // R17 R3
      assign cmp_b[p] = dir_reg ? (mid_reg[p] > cnt_reg) : (down_reg[p] > cnt_reg); // R18 R3

      tdpwm_deadtime u_dt (
         .mclk(mclk),
         .arst_n(arst_n),
         .run(run),
         .dir_up(dir_reg),
         .cmp_a(cmp_a[p]),
         .cmp_b(cmp_b[p]),
         .dead_time(dtv_reg),
         .dtw_a(dtw_a[p]),
         .dtw_b(dtw_b[p]),
         .cnt_even(dtc[2 * p]),
         .cnt_odd(dtc[2 * p + 1])
      );
   end

   // Output waves with level selection; a halted counter keeps the pins as they are.
   wire [2:0] og_a = cmp_a & dtw_b; // R16 R21
   wire [2:0] og_b = cmp_b & dtw_a; // R16 R21
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         out_a_reg <= 3'h0;
         out_b_reg <= 3'h0;
         carrier_toggle_out <= 1'b0;
      end else if (run) begin
         out_a_reg <= pls ? og_a : ~og_a; // R12
         out_b_reg <= nls ? og_b : ~og_b; // R12
         carrier_toggle_out <= dir_reg; // R22
      end
   end
   assign phase_u_out_a = out_a_reg[0];
   assign phase_u_out_b = out_b_reg[0];
   assign phase_v_out_a = out_a_reg[1];
   assign phase_v_out_b = out_b_reg[1];
   assign phase_w_out_a = out_a_reg[2];
   assign phase_w_out_b = out_b_reg[2];

   // Read selection; unmapped words read as zero and are still acknowledged.
   wire [1:0] mid_sel = pidx(wb_adr_i, tdpwm_pkg::OFS_MID);
   wire [1:0] up_sel = pidx(wb_adr_i, tdpwm_pkg::OFS_UP);
   wire [1:0] down_sel = pidx(wb_adr_i, tdpwm_pkg::OFS_DOWN);
   wire [7:0] dtc_off = wb_adr_i - tdpwm_pkg::OFS_DTC;
   wire dtc_hit = wb_adr_i >= tdpwm_pkg::OFS_DTC && dtc_off < 8'h18 && dtc_off[1:0] == 2'h0;
   wire [2:0] dtc_sel = dtc_off[4:2];
   always_comb begin
      rdat = 32'h0000_0000;
      if (wb_adr_i == tdpwm_pkg::OFS_CTRL) rdat[4:0] = ctrl_reg;
      else if (wb_adr_i == tdpwm_pkg::OFS_STAT) rdat[0] = dir_reg;
      else if (wb_adr_i == tdpwm_pkg::OFS_CNT) rdat[15:0] = cnt_reg;
      else if (wb_adr_i == tdpwm_pkg::OFS_DTV) rdat[15:0] = dtv_reg;
      else if (wb_adr_i == tdpwm_pkg::OFS_PBUF) rdat[15:0] = pbuf_reg;
      else if (wb_adr_i == tdpwm_pkg::OFS_PCMP) rdat[15:0] = pcmp_reg;
      else if (dbuf_sel != 2'h3) rdat[15:0] = dbuf_reg[dbuf_sel];
      else if (dfree_sel != 2'h3) rdat[15:0] = dbuf_reg[dfree_sel];
      else if (mid_sel != 2'h3) rdat[15:0] = mid_reg[mid_sel];
      else if (up_sel != 2'h3) rdat[15:0] = up_reg[up_sel];
      else if (down_sel != 2'h3) rdat[15:0] = down_reg[down_sel];
      else if (dtc_hit) rdat[15:0] = dtc[dtc_sel]; // R6
   end

   // One wait-free answer: ack one cycle after the request, then dropped.
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= req;
         if (req) wb_dat_o <= rdat;
      end
   end

   a_counter_hold: assert property (@(posedge mclk) disable iff (!arst_n) // R1
      !run && !clr_fall && !wr_cnt |=> $stable(cnt_reg))
      else $error("counter moved while stopped");
   a_crest_turn: assert property (@(posedge mclk) disable iff (!arst_n) // R2
      crest && !clr_fall && !wr_cnt |=> !dir_reg && cnt_reg == $past(cnt_reg) - 16'h0001)
      else $error("counter did not turn down at the period compare");
   a_trough_turn: assert property (@(posedge mclk) disable iff (!arst_n) // R2
      trough && !clr_fall && !wr_cnt |=> dir_reg && cnt_reg == $past(cnt_reg) + 16'h0001)
      else $error("counter did not turn up at twice the dead time");
   a_clear_reload: assert property (@(posedge mclk) disable iff (!arst_n) // R23
      clr_fall |=> dir_reg && cnt_reg == $past(two_td))
      else $error("counter clear did not reload twice the dead time");
   a_free_write: assert property (@(posedge mclk) disable iff (!arst_n) // R8
      wr_free && dfree_sel == 2'h0
      |=> mid_reg[0] == $past(wdat) + dtv_reg && down_reg[0] == $past(wdat))
      else $error("free duty write did not reach the compares at once");
   a_period_xfer: assert property (@(posedge mclk) disable iff (!arst_n) // R9
      xfer |=> pcmp_reg == $past(pbuf_reg) + $past(two_td))
      else $error("period compare not loaded on transfer");
   a_no_xfer: assert property (@(posedge mclk) disable iff (!arst_n) // R24
      crest && md == tdpwm_pkg::MD_TROUGH && !wr_pcmp |=> $stable(pcmp_reg))
      else $error("crest transfer in trough-only timing");
   a_toggle_dir: assert property (@(posedge mclk) disable iff (!arst_n) // R22
      run |=> carrier_toggle_out == $past(dir_reg))
      else $error("toggle output does not follow direction");
   a_out_level: assert property (@(posedge mclk) disable iff (!arst_n) // R21
      run |=> phase_u_out_a == ($past(cmp_a[0] & dtw_b[0]) ~^ $past(pls)))
      else $error("phase U output A wrong");
   a_ack_pulse: assert property (@(posedge mclk) disable iff (!arst_n)
      wb_ack_o |=> !wb_ack_o)
      else $error("ack held for more than one cycle");
endmodule

// ===== test/tdpwm_gate_stage.sv
// Behavioural gate-driver stage standing on the six PWM pins of the generator.
// Assumes the pins are registered on mclk and the active levels are given by the bench.
`timescale 1ns/1ps
module tdpwm_gate_stage (
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic pos_high,
   input wire logic neg_high,
   input wire logic u_a,
   input wire logic u_b,
   input wire logic v_a,
   input wire logic v_b,
   input wire logic w_a,
   input wire logic w_b,
   output logic overlap_seen,
   output logic [15:0] min_gap
);
   logic [2:0] a_on;
   logic [2:0] b_on;
   logic [15:0] idle_cnt [3];
   logic [15:0] gap_next;
   // A switch in the bridge conducts when its pin sits at the selected active level.
   assign a_on = {w_a == pos_high, v_a == pos_high, u_a == pos_high};
   assign b_on = {w_b == neg_high, v_b == neg_high, u_b == neg_high};
   // Both switches of one leg on at once would short the supply, so it is recorded.
   // Smallest gap closing in this cycle over all legs, so that one leg cannot hide another.
   always_comb begin
      gap_next = min_gap;
      for (int i = 0; i < 3; i++) begin
         if ((a_on[i] || b_on[i]) && idle_cnt[i] != 16'h0000 && idle_cnt[i] < gap_next) begin
            gap_next = idle_cnt[i];
         end
      end
   end
   // The shortest off gap before a switch turns on is kept for the dead-time check.
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         overlap_seen <= 1'b0;
         min_gap <= 16'hFFFF;
         for (int i = 0; i < 3; i++) idle_cnt[i] <= 16'h0000;
      end else begin
         for (int i = 0; i < 3; i++) begin
            if (a_on[i] && b_on[i]) overlap_seen <= 1'b1;
            if (!a_on[i] && !b_on[i]) idle_cnt[i] <= idle_cnt[i] + 16'h0001;
            else idle_cnt[i] <= 16'h0000;
         end
         min_gap <= gap_next;
      end
   end
endmodule

// ===== test/three_phase_deadtime_pwm_test.sv
// Self-checking bench for the three-phase dead-time PWM generator.
// Assumes the Wishbone map and timing codes of the design package.
`timescale 1ns/1ps
module three_phase_deadtime_pwm_test;
   typedef struct {logic we; logic [7:0] adr; logic [3:0] sel; logic [31:0] dat;} tdpwm_row_t;
   logic mclk = 1'b0;
   logic arst_n = 1'b0;
   logic wb_cyc = 1'b0;
   logic wb_stb = 1'b0;
   logic wb_we = 1'b0;
   logic [7:0] wb_adr = 8'h00;
   logic [3:0] wb_sel = 4'h0;
   logic [31:0] wb_wdat = 32'h00000000;
   logic [31:0] wb_rdat;
   logic wb_ack;
   logic counter_clear_n = 1'b1;
   logic lv = 1'b1;
   logic pu_a, pu_b, pv_a, pv_b, pw_a, pw_b, toggle;
   logic overlap_seen;
   logic [15:0] min_gap;
   logic [31:0] rd;
   int mismatches = 0;
   int compares = 0;
   int n;
   tdpwm_row_t rows [18];
   always #2.5 mclk = ~mclk;
   tdpwm_top dut (.mclk(mclk), .arst_n(arst_n), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
      .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat),
      .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .counter_clear_n(counter_clear_n),
      .phase_u_out_a(pu_a), .phase_u_out_b(pu_b), .phase_v_out_a(pv_a),
      .phase_v_out_b(pv_b), .phase_w_out_a(pw_a), .phase_w_out_b(pw_b),
      .carrier_toggle_out(toggle));
   tdpwm_gate_stage stage (.mclk(mclk), .arst_n(arst_n), .pos_high(lv), .neg_high(lv),
      .u_a(pu_a), .u_b(pu_b), .v_a(pv_a), .v_b(pv_b), .w_a(pw_a), .w_b(pw_b),
      .overlap_seen(overlap_seen), .min_gap(min_gap));
   // The verdict is printed in this one place, also when a wait runs out.
   task automatic complete_run();
      $display("checks %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // One classic cycle; the request stands until ack is sampled high at a rising edge.
   task automatic wb_cycle(input tdpwm_row_t r, output logic [31:0] data);
      int k;
      @(posedge mclk);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= r.we;
      wb_adr <= r.adr;
      wb_sel <= r.sel;
      wb_wdat <= r.dat;
      k = 0;
      do begin
         @(posedge mclk);
         k++;
      end while (wb_ack !== 1'b1 && k < 20);
      if (k >= 20) begin
         mismatches++;
         complete_run();
      end
      data = wb_rdat;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] adr, input logic [15:0] v);
      wb_cycle('{1'b1, adr, 4'hF, {16'h0000, v}}, rd);
   endtask
   task automatic rdv(input logic [7:0] adr);
      wb_cycle('{1'b0, adr, 4'hF, 32'h00000000}, rd);
   endtask
   // Waits for a level on the toggle pin and returns the cycles it took.
   task automatic wait_toggle(input logic lvl);
      n = 0;
      while (toggle !== lvl && n < 500) begin
         @(posedge mclk);
         n++;
      end
      if (n >= 500) begin
         mismatches++;
         complete_run();
      end
   endtask
   initial begin
      // Setup with dead time 3, period buffer 20; each read row carries its expected value.
      rows = '{'{1'b0, tdpwm_pkg::OFS_CTRL, 4'hF, 32'h0}, '{1'b0, tdpwm_pkg::OFS_STAT, 4'hF, 32'h1},
         '{1'b1, tdpwm_pkg::OFS_DTV, 4'hF, 32'h3}, '{1'b0, tdpwm_pkg::OFS_DTV, 4'hF, 32'h3},
         '{1'b1, tdpwm_pkg::OFS_CNT, 4'hF, 32'h6}, '{1'b0, tdpwm_pkg::OFS_CNT, 4'hF, 32'h6},
         '{1'b1, tdpwm_pkg::OFS_CNT, 4'hC, 32'h9}, '{1'b0, tdpwm_pkg::OFS_CNT, 4'hF, 32'h6},
         '{1'b1, tdpwm_pkg::OFS_PBUF, 4'hF, 32'h14}, '{1'b1, tdpwm_pkg::OFS_PCMP, 4'hF, 32'h1A},
         '{1'b1, tdpwm_pkg::OFS_DFREE, 4'hF, 32'hA}, '{1'b0, tdpwm_pkg::OFS_MID, 4'hF, 32'hD},
         '{1'b0, tdpwm_pkg::OFS_UP, 4'hF, 32'h10}, '{1'b0, tdpwm_pkg::OFS_DOWN, 4'hF, 32'hA},
         '{1'b1, 8'h1C, 4'hF, 32'h5}, '{1'b0, 8'h34, 4'hF, 32'h0},
         '{1'b1, tdpwm_pkg::OFS_STAT, 4'hF, 32'h0}, '{1'b0, 8'hFC, 4'hF, 32'h0}};
      repeat (4) @(posedge mclk);
      arst_n <= 1'b1;
      for (int i = 0; i < 18; i++) begin
         wb_cycle(rows[i], rd);
         if (!rows[i].we) check("register", rd, rows[i].dat);
      end
      rdv(tdpwm_pkg::OFS_STAT);
      check("status", rd, 32'h1);
      wr(8'h28, 16'h0008);
      wr(8'h2C, 16'h000C);
      // The free write also loads the V buffer, so the buffered value is written again.
      wr(8'h1C, 16'h0005);
      // Run with crest transfer and active-high levels on both sides.
      wr(tdpwm_pkg::OFS_CTRL, 16'h001B);
      wait_toggle(1'b0);
      wait_toggle(1'b1);
      wait_toggle(1'b0);
      // The first rise starts at twice the dead time, so it is one step longer.
      check("first up width", n, 32'd21);
      wait_toggle(1'b1);
      wait_toggle(1'b0);
      check("up width", n, 32'd20);
      wait_toggle(1'b1);
      check("down width", n, 32'd20);
      rdv(8'h1C);
      check("buffer", rd, 32'h5);
      rdv(8'h34);
      check("crest transfer", rd, 32'h8);
      wr(tdpwm_pkg::OFS_CNT, 16'h0000);
      rdv(tdpwm_pkg::OFS_CNT);
      check("count write refused", rd[15:0] >= 16'h0006, 32'h1);
      repeat (60) @(posedge mclk);
      check("overlap", overlap_seen, 32'h0);
      check("dead gap", min_gap >= 16'h0003, 32'h1);
      // External clear reloads twice the dead time and starts upward.
      wait_toggle(1'b0);
      counter_clear_n <= 1'b0;
      @(posedge mclk);
      counter_clear_n <= 1'b1;
      rdv(tdpwm_pkg::OFS_CNT);
      check("clear count", rd[15:0] >= 16'h0006 && rd[15:0] <= 16'h000B, 32'h1);
      check("clear direction", toggle, 32'h1);
      // A halt freezes busy dead-time counters, so stop on the way down from the crest.
      wait_toggle(1'b0);
      // Leaving the operating mode halts the counter and holds the pins.
      wr(tdpwm_pkg::OFS_CTRL, 16'h0018);
      rdv(tdpwm_pkg::OFS_CNT);
      n = rd;
      repeat (10) @(posedge mclk);
      rdv(tdpwm_pkg::OFS_CNT);
      check("held count", rd, n);
      repeat (5) @(posedge mclk);
      for (int i = 0; i < 6; i++) begin
         rdv(tdpwm_pkg::OFS_DTC + 8'(4 * i));
         check("dead counter idle", rd, 32'h0);
      end
      // Zero dead time: counters never start and the free duty lands at once.
      wr(tdpwm_pkg::OFS_DTV, 16'h0000);
      wr(tdpwm_pkg::OFS_DFREE, 16'h0007);
      rdv(tdpwm_pkg::OFS_UP);
      check("zero dead up", rd, 32'h7);
      wr(tdpwm_pkg::OFS_DBUF, 16'h0002);
      rdv(tdpwm_pkg::OFS_MID);
      check("buffered held", rd, 32'h7);
      // Trough-only transfer with active-low levels; the stage follows the new levels.
      lv <= 1'b0;
      wr(tdpwm_pkg::OFS_CTRL, 16'h0005);
      wait_toggle(1'b1);
      rdv(tdpwm_pkg::OFS_MID);
      check("trough transfer", rd, 32'h2);
      rdv(tdpwm_pkg::OFS_PCMP);
      check("trough period", rd, 32'h14);
      // A new period written before the crest must wait for the next trough.
      wr(tdpwm_pkg::OFS_PBUF, 16'h0010);
      wait_toggle(1'b0);
      rdv(tdpwm_pkg::OFS_PCMP);
      check("crest skipped", rd, 32'h14);
      check("overlap low level", overlap_seen, 32'h0);
      complete_run();
   end
endmodule
